// [rtl/ppt_pkg.sv]
// Constants for the PoE port I2C register target
package ppt_pkg;
    // ------------------------------------------------------------
    // Bus addressing
    // ------------------------------------------------------------
    localparam logic [6:0] ADDR_SEL_LOW = 7'h20;
    localparam logic [6:0] ADDR_SEL_HIGH = 7'h21;
    localparam logic [6:0] ADDR_BROADCAST = 7'h00;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // ------------------------------------------------------------
    // Register offsets and fields
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PORT_MODE_CONFIG = 8'h00;
    localparam logic [7:0] OFS_PORT_VOLTAGE_LOW = 8'h02;
    localparam logic [7:0] OFS_PORT_VOLTAGE_HIGH = 8'h03;
    localparam int CLASS_LSB = 0;
    localparam int SPARE_BIT = 3;
    localparam int PAIR_LSB = 4;
    localparam int FRESH_BIT = 2;
    localparam logic [2:0] CLASS_RESET = 3'h7;
    localparam logic [2:0] PAIR_RESET = 3'h7;
    localparam logic SPARE_RESET = 1'b0;
    localparam int VOLT_WIDTH = 10;
    localparam int VOLT_LSB_UV = 58600; // Microvolts per count of the reading
    // ------------------------------------------------------------
    // Power class codes and their currents in mA
    // ------------------------------------------------------------
    localparam logic [2:0] CLS_LOW0 = 3'h0;
    localparam logic [2:0] CLS_LOW1 = 3'h1;
    localparam logic [2:0] CLS_LOW2 = 3'h2;
    localparam logic [2:0] CLS_LOW3 = 3'h3;
    localparam logic [2:0] CLS_HIGH1 = 3'h4;
    localparam logic [2:0] CLS_HIGH2 = 3'h5;
    localparam logic [2:0] CLS_HIGH3 = 3'h6;
    localparam logic [2:0] CLS_HIGH = 3'h7;
    localparam logic [9:0] CUT_LOW0_MA = 10'd375;
    localparam logic [9:0] LIM_LOW0_MA = 10'd425;
    localparam logic [9:0] LIM_LOW1_MA = 10'd110;
    localparam logic [9:0] LIM_LOW2_MA = 10'd195;
    localparam logic [9:0] LIM_LOW3_MA = 10'd280;
    localparam logic [9:0] LIM_HIGH1_MA = 10'd485;
    localparam logic [9:0] LIM_HIGH2_MA = 10'd607;
    localparam logic [9:0] LIM_HIGH3_MA = 10'd970;
    localparam logic [9:0] CUT_HIGH_MA = 10'd642;
    localparam logic [9:0] LIM_HIGH_MA = 10'd720;
    localparam logic [9:0] NO_CUTOFF_MA = 10'h000;
    // ------------------------------------------------------------
    // Pair-set codes
    // ------------------------------------------------------------
    localparam logic [2:0] PAIR_B_RES = 3'h0;
    localparam logic [2:0] PAIR_A_RES = 3'h2;
    localparam logic [2:0] PAIR_A_CAP = 3'h3;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam real CLK_FREQ_HZ = 100.0e6;
    localparam real WDOG_TIME_S = 0.5;
    localparam real REFRESH_TIME_MS = 1.0;
    localparam int WDOG_CYCLES_DEF = int'($floor(WDOG_TIME_S * CLK_FREQ_HZ));
    localparam int REFRESH_CYCLES_DEF = int'($floor(REFRESH_TIME_MS * CLK_FREQ_HZ / 1000.0));
    // ------------------------------------------------------------
    // Bus engine states
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
        ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_HOST_ACK
    } ppt_state_t;
endpackage : ppt_pkg

// [rtl/ppt_target.sv]
// I2C target with port mode and port voltage registers
`timescale 1ns/1ps
`default_nettype none
module ppt_target import ppt_pkg::*; #(
    parameter int WDOG_CYCLES = WDOG_CYCLES_DEF,
    parameter int REFRESH_CYCLES = REFRESH_CYCLES_DEF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic addr_sel,
    input wire logic [VOLT_WIDTH-1:0] port_voltage,
    input wire logic [2:0] mode_resistor_msb,
    input wire logic mode_resistor_valid,
    output logic [2:0] power_class_select,
    output logic [2:0] pair_set_select,
    output logic cutoff_enable,
    output logic [9:0] cutoff_current_ma,
    output logic [9:0] current_limit_ma,
    output logic classify_enable,
    output logic alt_a_select,
    output logic cap_detect_enable
);
    localparam int WDW = $clog2(WDOG_CYCLES + 1);
    localparam int RFW = $clog2(REFRESH_CYCLES + 1);
    localparam logic [WDW-1:0] WDOG_LAST = WDW'(WDOG_CYCLES - 1);
    localparam logic [RFW-1:0] REFRESH_LAST = RFW'(REFRESH_CYCLES - 1);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (WDOG_CYCLES < 2) begin : g_chk_wdog
        $error("WDOG_CYCLES must be at least 2");
    end
    if (REFRESH_CYCLES < 2) begin : g_chk_ref
        $error("REFRESH_CYCLES must be at least 2");
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Own address or broadcast
    function automatic logic addr_match(input logic [6:0] a, input logic sel);
        return (a == (sel ? ADDR_SEL_HIGH : ADDR_SEL_LOW)) || (a == ADDR_BROADCAST);
    endfunction : addr_match

    // ------------------------------------------------------------
    // Pin synchronisers and edge detect
    // ------------------------------------------------------------
    logic scl_meta_q, scl_sync_q, scl_prev_q;
    logic sda_meta_q, sda_sync_q, sda_prev_q;
    logic sel_meta_q, sel_sync_q;
    logic scl_rise, scl_fall, bus_start, bus_stop;

    // Two synchroniser flops per pin, plus a third on SCL and SDA for edge detect; the bus is oversampled by clk, so SCL must run well below the clk rate
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {scl_meta_q, scl_sync_q, scl_prev_q} <= 3'h7;
            {sda_meta_q, sda_sync_q, sda_prev_q} <= 3'h7;
            {sel_meta_q, sel_sync_q} <= 2'h0;
        end else begin
            {scl_meta_q, scl_sync_q, scl_prev_q} <= {scl_in, scl_meta_q, scl_sync_q};
            {sda_meta_q, sda_sync_q, sda_prev_q} <= {sda_in, sda_meta_q, sda_sync_q};
            {sel_meta_q, sel_sync_q} <= {addr_sel, sel_meta_q};
        end
    end

    // Bus conditions
    assign scl_rise = scl_sync_q && !scl_prev_q;
    assign scl_fall = !scl_sync_q && scl_prev_q;
    assign bus_start = scl_sync_q && scl_prev_q && !sda_sync_q && sda_prev_q;
    assign bus_stop = scl_sync_q && scl_prev_q && sda_sync_q && !sda_prev_q;

    // ------------------------------------------------------------
    // Bus engine
    // ------------------------------------------------------------
    ppt_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d, tx_q, tx_d, ptr_q, ptr_d, rd_data;
    logic rw_q, rw_d, sda_low_q, sda_low_d;
    logic wr_stb, rd_stb, wd_expire;
    logic [WDW-1:0] wd_q, wd_d;
    logic [VOLT_WIDTH-1:0] volt_q, volt_d;
    logic [1:0] snap_q, snap_d;
    logic fresh_q, fresh_d;
    logic [6:0] mode_q, mode_d;

    // Read mux; unmapped offsets read zero
    always_comb begin
        case (ptr_q)
            OFS_PORT_MODE_CONFIG: rd_data = {1'b0, mode_q};
            OFS_PORT_VOLTAGE_LOW: rd_data = volt_q[7:0];
            OFS_PORT_VOLTAGE_HIGH: rd_data = {5'h00, fresh_q, snap_q};
            default: rd_data = 8'h00;
        endcase
    end

    // Byte engine; only SDA is ever driven, SCL is input only
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        tx_d = tx_q;
        ptr_d = ptr_q;
        rw_d = rw_q;
        sda_low_d = sda_low_q;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        if (bus_start) begin
            state_d = ST_ADDR;
            cnt_d = 4'h0;
            sda_low_d = 1'b0;
        end else if (bus_stop || wd_expire) begin
            state_d = ST_IDLE;
            sda_low_d = 1'b0;
        end else begin
            case (state_q)
                ST_ADDR, ST_REG, ST_WDATA: begin
                    if (scl_rise) begin
                        sh_d = {sh_q[6:0], sda_sync_q};
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                        cnt_d = 4'h0;
                        sda_low_d = 1'b1;
                        if (state_q == ST_ADDR) begin
                            if (addr_match(sh_q[7:1], sel_sync_q)) begin
                                rw_d = sh_q[0];
                                state_d = ST_ADDR_ACK;
                            end else begin
                                sda_low_d = 1'b0;
                                state_d = ST_IDLE;
                            end
                        end else if (state_q == ST_REG) begin
                            ptr_d = sh_q;
                            state_d = ST_REG_ACK;
                        end else begin
                            wr_stb = 1'b1;
                            state_d = ST_WDATA_ACK;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            rd_stb = 1'b1;
                            tx_d = rd_data;
                            sda_low_d = !rd_data[7];
                            state_d = ST_RDATA;
                        end else begin
                            sda_low_d = 1'b0;
                            state_d = ST_REG;
                        end
                    end
                end
                ST_REG_ACK, ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        sda_low_d = 1'b0;
                        if (state_q == ST_WDATA_ACK) begin
                            ptr_d = ptr_q + 8'h01;
                        end
                        state_d = ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == BITS_PER_BYTE) begin
                            cnt_d = 4'h0;
                            sda_low_d = 1'b0;
                            state_d = ST_HOST_ACK;
                        end else begin
                            tx_d = {tx_q[6:0], 1'b0};
                            sda_low_d = !tx_q[6];
                        end
                    end
                end
                ST_HOST_ACK: begin
                    if (scl_rise) begin
                        if (sda_sync_q) begin
                            state_d = ST_IDLE; // Host ended the read
                        end else begin
                            ptr_d = ptr_q + 8'h01;
                        end
                    end else if (scl_fall) begin
                        rd_stb = 1'b1;
                        tx_d = rd_data;
                        sda_low_d = !rd_data[7];
                        state_d = ST_RDATA;
                    end
                end
                default: begin
                    sda_low_d = 1'b0;
                end
            endcase
        end
    end

    // Watchdog: clears when idle, on any SCL edge, or on expiry
    always_comb begin
        wd_expire = (state_q != ST_IDLE) && (wd_q == WDOG_LAST);
        if (state_q == ST_IDLE || scl_rise || scl_fall || wd_expire) begin
            wd_d = '0;
        end else begin
            wd_d = wd_q + WDW'(1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'h00;
            ptr_q <= 8'h00;
            rw_q <= 1'b0;
            sda_low_q <= 1'b0;
            wd_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            tx_q <= tx_d;
            ptr_q <= ptr_d;
            rw_q <= rw_d;
            sda_low_q <= sda_low_d;
            wd_q <= wd_d;
        end
    end

    // Open-drain SDA: only ever pulled low
    assign sda_out = 1'b0;
    assign sda_oe_n = !sda_low_q;

    // ------------------------------------------------------------
    // Voltage sampling and registers
    // ------------------------------------------------------------
    logic [RFW-1:0] ref_q, ref_d;
    logic tick, init_q, init_d;
    logic [9:0] cut_d, lim_d;
    logic cut_en_d, cls_en_d, alt_a_d, cap_d;

    always_comb begin
        tick = (ref_q == REFRESH_LAST);
        ref_d = tick ? '0 : ref_q + RFW'(1);
        volt_d = tick ? port_voltage : volt_q;
        snap_d = snap_q;
        fresh_d = fresh_q;
        if (rd_stb && ptr_q == OFS_PORT_VOLTAGE_LOW) begin
            snap_d = volt_q[VOLT_WIDTH-1:8];
        end
        // A new sample wins over the clearing read
        if (tick) begin
            fresh_d = 1'b1;
        end else if (rd_stb && ptr_q == OFS_PORT_VOLTAGE_HIGH) begin
            fresh_d = 1'b0;
        end
        mode_d = mode_q;
        init_d = init_q || mode_resistor_valid;
        if (wr_stb && ptr_q == OFS_PORT_MODE_CONFIG) begin
            mode_d = sh_q[6:0];
        end else if (mode_resistor_valid && !init_q) begin
            mode_d[PAIR_LSB+:3] = mode_resistor_msb;
        end
        // Class decode; zero cutoff means cutoff disabled
        cut_en_d = 1'b0;
        cut_d = NO_CUTOFF_MA;
        cls_en_d = 1'b0;
        case (mode_d[CLASS_LSB+:3])
            CLS_LOW0: begin
                cut_en_d = 1'b1;
                cut_d = CUT_LOW0_MA;
                lim_d = LIM_LOW0_MA;
            end
            CLS_LOW1: lim_d = LIM_LOW1_MA;
            CLS_LOW2: lim_d = LIM_LOW2_MA;
            CLS_LOW3: lim_d = LIM_LOW3_MA;
            CLS_HIGH1: lim_d = LIM_HIGH1_MA;
            CLS_HIGH2: lim_d = LIM_HIGH2_MA;
            CLS_HIGH3: begin
                cls_en_d = 1'b1;
                lim_d = LIM_HIGH3_MA;
            end
            default: begin
                cut_en_d = 1'b1;
                cls_en_d = 1'b1;
                cut_d = CUT_HIGH_MA;
                lim_d = LIM_HIGH_MA;
            end
        endcase
        // Pair-set decode
        alt_a_d = (mode_d[PAIR_LSB+:3] == PAIR_A_RES) || (mode_d[PAIR_LSB+:3] == PAIR_A_CAP);
        cap_d = (mode_d[PAIR_LSB+:3] != PAIR_B_RES) && (mode_d[PAIR_LSB+:3] != PAIR_A_RES);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ref_q <= '0;
            volt_q <= '0;
            snap_q <= 2'h0;
            fresh_q <= 1'b0;
            init_q <= 1'b0;
            mode_q <= {PAIR_RESET, SPARE_RESET, CLASS_RESET};
            cutoff_enable <= 1'b1;
            cutoff_current_ma <= CUT_HIGH_MA;
            current_limit_ma <= LIM_HIGH_MA;
            classify_enable <= 1'b1;
            alt_a_select <= 1'b0;
            cap_detect_enable <= 1'b1;
        end else begin
            ref_q <= ref_d;
            volt_q <= volt_d;
            snap_q <= snap_d;
            fresh_q <= fresh_d;
            init_q <= init_d;
            mode_q <= mode_d;
            cutoff_enable <= cut_en_d;
            cutoff_current_ma <= cut_d;
            current_limit_ma <= lim_d;
            classify_enable <= cls_en_d;
            alt_a_select <= alt_a_d;
            cap_detect_enable <= cap_d;
        end
    end

    assign power_class_select = mode_q[CLASS_LSB+:3];
    assign pair_set_select = mode_q[PAIR_LSB+:3];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_ADDR_ACK: assert property (@(posedge clk) disable iff (!nrst)
        (state_q == ST_ADDR && scl_fall && cnt_q == BITS_PER_BYTE && !bus_start && !bus_stop && !wd_expire
         && addr_match(sh_q[7:1], sel_sync_q)) |=> (state_q == ST_ADDR_ACK && !sda_oe_n))
        else $error("matching address not acknowledged");
    AST_ADDR_NACK: assert property (@(posedge clk) disable iff (!nrst)
        (state_q == ST_ADDR && scl_fall && cnt_q == BITS_PER_BYTE && !bus_start
         && !addr_match(sh_q[7:1], sel_sync_q)) |=> (state_q == ST_IDLE && sda_oe_n))
        else $error("foreign address acknowledged");
    AST_WDOG: assert property (@(posedge clk) disable iff (!nrst)
        (wd_expire && !bus_start) |=> (state_q == ST_IDLE && sda_oe_n && wd_q == '0))
        else $error("watchdog did not return engine to idle");
    AST_IDLE_RELEASE: assert property (@(posedge clk) disable iff (!nrst)
        (state_q == ST_IDLE || state_q == ST_ADDR) |-> sda_oe_n)
        else $error("SDA driven outside a transfer");
    AST_MODE_WRITE: assert property (@(posedge clk) disable iff (!nrst)
        (wr_stb && ptr_q == OFS_PORT_MODE_CONFIG) |=> (mode_q == $past(sh_q[6:0])))
        else $error("mode write not stored");
    AST_FRESH_CLR: assert property (@(posedge clk) disable iff (!nrst)
        (rd_stb && ptr_q == OFS_PORT_VOLTAGE_HIGH && !tick) |=> !fresh_q)
        else $error("fresh flag not cleared by read");
    AST_REFRESH: assert property (@(posedge clk) disable iff (!nrst)
        tick |=> (fresh_q && volt_q == $past(port_voltage)) ##1 (ref_q == RFW'(1)))
        else $error("voltage sample not taken");
    AST_SNAP: assert property (@(posedge clk) disable iff (!nrst)
        (rd_stb && ptr_q == OFS_PORT_VOLTAGE_LOW) |=> (snap_q == $past(volt_q[9:8])))
        else $error("high bits not captured at low read");
    AST_CLASS_HIGH: assert property (@(posedge clk) disable iff (!nrst)
        (mode_q[CLASS_LSB+:3] == CLS_HIGH) |-> (current_limit_ma == LIM_HIGH_MA && cutoff_enable))
        else $error("class 7 limit wrong");
endmodule : ppt_target
`default_nettype wire

// [test/ppt_host.sv]
// Host bus controller model that drives the bus clock and the data line
`timescale 1ns/1ps
`default_nettype none
module ppt_host (
    output logic scl,
    output logic sda_o,
    input wire logic sda
);
    // ----------------------------------------
    // Bit and byte level
    // ----------------------------------------
    localparam realtime QTR = 31.25; // Quarter of the 125 ns bus period
    // Both lines released while idle
    initial begin
        scl = 1'b1;
        sda_o = 1'b1;
    end
    // One bit: data changes while clock low, sampled while high
    task automatic bit_io(input logic b, output logic r);
        sda_o = b;
        #QTR scl = 1'b1;
        #QTR r = sda;
        #QTR scl = 1'b0;
        #QTR;
    endtask : bit_io
    // Start or repeated start: data falls while clock high
    task automatic start();
        sda_o = 1'b1;
        #QTR scl = 1'b1;
        #QTR sda_o = 1'b0;
        #QTR scl = 1'b0;
        #QTR;
    endtask : start
    // Stop: data rises while clock high, then clock stands still
    task automatic stop();
        sda_o = 1'b0;
        #QTR scl = 1'b1;
        #QTR sda_o = 1'b1;
        #(2 * QTR);
    endtask : stop
    // Byte out, most significant bit first; returns the acknowledge
    task automatic put(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
        end
        bit_io(1'b1, r);
        ack = ~r;
    endtask : put
    // Byte in; the last byte is answered with a not-acknowledge
    task automatic get(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            b[i] = r;
        end
        bit_io(last, r);
    endtask : get
endmodule : ppt_host
`default_nettype wire

// [test/testbench.sv]
// Self-checking testbench for the port mode and voltage bus target
`timescale 1ns/1ps
`default_nettype none
`define CHECK(what, exp, got) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) begin \
            miscompares++; \
            $display("Error %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module testbench import ppt_pkg::*; ();
    // ----------------------------------------
    // Setup
    // ----------------------------------------
    localparam int WDOG = 2000;
    localparam int REF = 5000;
    localparam logic [9:0] LIM [8] = '{LIM_LOW0_MA, LIM_LOW1_MA, LIM_LOW2_MA, LIM_LOW3_MA,
                                       LIM_HIGH1_MA, LIM_HIGH2_MA, LIM_HIGH3_MA, LIM_HIGH_MA};
    logic clk, nrst, scl, host_sda, sda_out, sda_oe_n, addr_sel, mr_valid;
    logic cut_en, cls_en, alt_a, cap_en;
    logic [9:0] port_voltage, cut_ma, lim_ma;
    logic [2:0] mr_msb, cls, pair;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;
    // Open-drain data wire with pull-up
    wire sda_w = (sda_oe_n ? 1'b1 : sda_out) & host_sda;
    ppt_target #(.WDOG_CYCLES(WDOG), .REFRESH_CYCLES(REF)) u_ppt_target (
        .clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .addr_sel(addr_sel), .port_voltage(port_voltage), .mode_resistor_msb(mr_msb),
        .mode_resistor_valid(mr_valid), .power_class_select(cls), .pair_set_select(pair),
        .cutoff_enable(cut_en), .cutoff_current_ma(cut_ma), .current_limit_ma(lim_ma),
        .classify_enable(cls_en), .alt_a_select(alt_a), .cap_detect_enable(cap_en));
    ppt_host u_ppt_host (.scl(scl), .sda_o(host_sda), .sda(sda_w));
    // System clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Cycles since reset release, to line up with voltage samples
    always @(posedge clk) cyc <= nrst ? cyc + 1 : 0;
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic wr(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] d, input logic exp);
        logic k, k2;
        u_ppt_host.start();
        u_ppt_host.put({a, 1'b0}, k);
        u_ppt_host.put(ofs, k2);
        u_ppt_host.put(d, k2);
        u_ppt_host.stop();
        `CHECK("address acknowledge", exp, k)
    endtask : wr
    task automatic chk_rd(input logic [6:0] a, input logic [7:0] ofs, input logic [7:0] exp);
        logic k0, k1, k2;
        logic [7:0] d;
        u_ppt_host.start();
        u_ppt_host.put({a, 1'b0}, k0);
        u_ppt_host.put(ofs, k1);
        u_ppt_host.start();
        u_ppt_host.put({a, 1'b1}, k2);
        u_ppt_host.get(1'b1, d);
        u_ppt_host.stop();
        `CHECK("read acknowledges", 3'h7, {k0, k1, k2})
        `CHECK("register read", exp, d)
    endtask : chk_rd
    task automatic chk_out(input logic [2:0] c, input logic [2:0] p);
        `CHECK("power class", c, cls)
        `CHECK("pair set", p, pair)
        `CHECK("cutoff enable", (c == 3'h0 || c == 3'h7), cut_en)
        `CHECK("cutoff current", (c == 3'h0) ? CUT_LOW0_MA : (c == 3'h7) ? CUT_HIGH_MA : NO_CUTOFF_MA, cut_ma)
        `CHECK("current limit", LIM[c], lim_ma)
        `CHECK("classify", c[2] & c[1], cls_en)
        `CHECK("alt A", (p == 3'h2 || p == 3'h3), alt_a)
        `CHECK("cap detect", (p != 3'h0 && p != 3'h2), cap_en)
    endtask : chk_out
    task automatic wait_sample();
        @(posedge clk);
        while (cyc % REF != 10) @(posedge clk);
    endtask : wait_sample
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        chk_out(3'h7, 3'h7);
        chk_rd(ADDR_SEL_LOW, OFS_PORT_MODE_CONFIG, 8'h77);
    endtask : t_reset
    task automatic t_load();
        @(posedge clk);
        mr_msb <= 3'h2;
        mr_valid <= 1'b1;
        @(posedge clk);
        mr_valid <= 1'b0;
        mr_msb <= 3'h5;
        repeat (3) @(posedge clk);
        chk_out(3'h7, 3'h2);
        mr_valid <= 1'b1;
        repeat (3) @(posedge clk);
        chk_out(3'h7, 3'h2);
    endtask : t_load
    task automatic t_modes();
        logic [6:0] a;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            addr_sel <= i[0];
            a = (i == 6) ? ADDR_BROADCAST : i[0] ? ADDR_SEL_HIGH : ADDR_SEL_LOW;
            repeat (4) @(posedge clk);
            wr(a, OFS_PORT_MODE_CONFIG, {1'b0, i[2:0], i[0], i[2:0]}, 1'b1);
            repeat (2) @(posedge clk);
            chk_out(i[2:0], i[2:0]);
            chk_rd(a, OFS_PORT_MODE_CONFIG, {1'b0, i[2:0], i[0], i[2:0]});
        end
        wr(ADDR_SEL_LOW, OFS_PORT_MODE_CONFIG, 8'h00, 1'b0);
        chk_out(3'h7, 3'h7);
    endtask : t_modes
    task automatic t_volt();
        @(posedge clk);
        port_voltage <= 10'h2A5;
        repeat (2) wait_sample();
        chk_rd(ADDR_SEL_HIGH, OFS_PORT_VOLTAGE_LOW, 8'hA5);
        @(posedge clk);
        port_voltage <= 10'h15A;
        chk_rd(ADDR_SEL_HIGH, OFS_PORT_VOLTAGE_HIGH, 8'h06);
        chk_rd(ADDR_SEL_HIGH, OFS_PORT_VOLTAGE_HIGH, 8'h02);
        wait_sample();
        chk_rd(ADDR_SEL_HIGH, OFS_PORT_VOLTAGE_HIGH, 8'h06);
        chk_rd(ADDR_SEL_HIGH, OFS_PORT_VOLTAGE_LOW, 8'h5A);
        chk_rd(ADDR_SEL_HIGH, OFS_PORT_VOLTAGE_HIGH, 8'h01);
    endtask : t_volt
    task automatic t_wdog();
        logic r;
        logic [7:0] b;
        b = {ADDR_SEL_HIGH, 1'b0};
        u_ppt_host.start();
        for (int i = 7; i >= 0; i--) u_ppt_host.bit_io(b[i], r);
        repeat (2) @(posedge clk);
        `CHECK("acknowledge driven", 1'b0, sda_oe_n)
        repeat (WDOG - 100) @(posedge clk);
        `CHECK("held before timeout", 1'b0, sda_oe_n)
        repeat (200) @(posedge clk);
        `CHECK("released after timeout", 1'b1, sda_oe_n)
        u_ppt_host.stop();
        chk_rd(ADDR_SEL_HIGH, OFS_PORT_MODE_CONFIG, 8'h7F);
    endtask : t_wdog
    // Main sequence
    initial begin
        nrst = 1'b0;
        addr_sel = 1'b0;
        port_voltage = 10'h000;
        mr_msb = 3'h0;
        mr_valid = 1'b0;
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset();
        t_load();
        t_modes();
        t_volt();
        t_wdog();
        print_verdict();
    end
    // Hang guard, well beyond the expected run length
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
